// *** fwsf_pkg.sv ***
// fwsf_pkg: constants, command codes and carrier types for the flash status-poll controller.
// assumes a byte-wide flash with a 21-bit byte address and REF_CLK at 20 MHz.
package fwsf_pkg;

    // ------------------------------------------------------------------
    // widths and clock
    // ------------------------------------------------------------------
    localparam int AW     = 21;
    localparam int CLK_NS = 50;

    // ------------------------------------------------------------------
    // host-side bus timing, in ns or us, and derived cycle counts
    // ------------------------------------------------------------------
    localparam int T_WP_NS     = 100;  // write strobe low time
    localparam int T_ACC_NS    = 120;  // read access allowance
    localparam int T_SUSP_US   = 15;   // longest time to reach suspend
    localparam int T_SEWIN_US  = 50;   // sector-erase timeout window
    localparam int SYNC_STAGES = 3;
    localparam logic [3:0]  WP_CYC    = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  ACC_CYC   = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
    localparam logic [10:0] SUSP_CYC  = 11'((T_SUSP_US * 1000 + CLK_NS - 1) / CLK_NS);
    // window is a longest time for the host: round down
    localparam logic [10:0] SEWIN_CYC = 11'((T_SEWIN_US * 1000) / CLK_NS);

    // ------------------------------------------------------------------
    // command-cycle addresses and data
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] UNLOCK_A1 = 21'h000555;
    localparam logic [AW-1:0] UNLOCK_A2 = 21'h0002AA;
    localparam logic [7:0] UNLOCK_D1  = 8'hAA;
    localparam logic [7:0] UNLOCK_D2  = 8'h55;
    localparam logic [7:0] CMD_PROG   = 8'hA0;
    localparam logic [7:0] CMD_ESETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP   = 8'h10;
    localparam logic [7:0] CMD_SECT   = 8'h30;
    localparam logic [7:0] CMD_SUSP   = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_RESET  = 8'hF0;

    // ------------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------------
    localparam int POLL_STATUS_BIT   = 7;
    localparam int TOGGLE_STATUS_BIT = 6;
    localparam int TIMEOUT_FAIL_BIT  = 5;
    localparam int ERASE_WINDOW_BIT  = 3;

    // ------------------------------------------------------------------
    // user operations and carriers
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ     = 3'h0,
        OP_PROG     = 3'h1,
        OP_CHIP     = 3'h2,
        OP_SECT     = 3'h3,
        OP_ADD_SECT = 3'h4,
        OP_SUSPEND  = 3'h5,
        OP_RESUME   = 3'h6,
        OP_POLL     = 3'h7
    } fwsf_op_t;

    typedef struct packed {
        fwsf_op_t        op;
        logic [AW-1:0]   addr;
        logic [7:0]      data;
    } fwsf_cmd_t;

    typedef struct packed {
        logic [7:0]      data;
        logic            fail;
        logic            reject;
    } fwsf_rsp_t;

    typedef struct packed {
        logic [AW-1:0]   addr;
        logic [7:0]      data;
        logic            last;
    } fwsf_cyc_t;

endpackage : fwsf_pkg

// *** fwsf_host.sv ***
// fwsf_host: host controller that writes command sequences to a byte-wide flash
// and reads its progress flags until the program or erase has ended.
// assumes the flash pins are wired straight to this block and the flash runs unclocked.
//
// Overview of operation
// - suspend flips poll bit to 1; host reads the erasing sector to see it
// - host polls erase inside an erasing, unprotected sector
// - poll bit may flip before other bits are valid; host re-reads
// - programming 1 over 0 locks up with fail bit 1; host resets device
// - host checks erase window bit before and after each extra sector
`timescale 1ns/1ps
`default_nettype none

module fwsf_host (
    input  wire logic                    REF_CLK,
    input  wire logic                    ARST_N,
    input  wire logic                    CMD_VALID,
    input  wire fwsf_pkg::fwsf_cmd_t     CMD,
    output var  logic                    CMD_READY,
    output var  logic                    RSP_VALID,
    output var  fwsf_pkg::fwsf_rsp_t     RSP,
    output var  logic                    CE_N,
    output var  logic                    OE_N,
    output var  logic                    WE_N,
    output var  logic [fwsf_pkg::AW-1:0] ADDR,
    input  wire logic [7:0]              DQ_IN,
    output var  logic [7:0]              DQ_OUT,
    output var  logic                    DQ_OE
);
    import fwsf_pkg::*;

    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_WRITE = 5'b00010,
        S_READ  = 5'b00100,
        S_EVAL  = 5'b01000,
        S_WAIT  = 5'b10000
    } fwsf_state_t;

    // ------------------------------------------------------------------
    // command-cycle table
    // ------------------------------------------------------------------
    function automatic fwsf_cyc_t seq_cycle(input fwsf_op_t op, input logic [2:0] idx,
                                            input logic [AW-1:0] a, input logic [7:0] d);
        fwsf_cyc_t c;
        c.last = 1'b0;
        // unlock pairs sit at steps 0-1 and 3-4; step 2 is overridden below
        c.addr = (idx == 3'h1 || idx == 3'h4) ? UNLOCK_A2 : UNLOCK_A1;
        c.data = (idx == 3'h1 || idx == 3'h4) ? UNLOCK_D2 : UNLOCK_D1;
        unique case (op)
            OP_PROG: begin
                if (idx == 3'h2) c.data = CMD_PROG;
                if (idx == 3'h3) begin
                    c.addr = a;
                    c.data = d;
                    c.last = 1'b1;
                end
            end
            OP_CHIP, OP_SECT: begin
                if (idx == 3'h2) c.data = CMD_ESETUP;
                if (idx == 3'h5) begin
                    c.addr = (op == OP_SECT) ? a : UNLOCK_A1;
                    c.data = (op == OP_SECT) ? CMD_SECT : CMD_CHIP;
                    c.last = 1'b1;
                end
            end
            default: begin
                // single-cycle commands; address is don't-care except extra sector
                c.addr = a;
                c.data = (op == OP_ADD_SECT) ? CMD_SECT :
                         (op == OP_SUSPEND)  ? CMD_SUSP :
                         (op == OP_RESUME)   ? CMD_RESUME : CMD_RESET;
                c.last = 1'b1;
            end
        endcase
        return c;
    endfunction : seq_cycle

    // ------------------------------------------------------------------
    // data pin synchroniser
    // ------------------------------------------------------------------
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic [7:0] dq_s3;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
            dq_s3 <= 8'h00;
        end else begin
            dq_s1 <= DQ_IN;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
        end
    end

    // ------------------------------------------------------------------
    // sector-erase window tracker
    // ------------------------------------------------------------------
    fwsf_state_t   state;
    fwsf_cmd_t     cmd;
    fwsf_cyc_t     cyc;
    logic [2:0]    idx;
    logic [3:0]    ph;
    logic [10:0]   wait_cnt;
    logic [10:0]   win_cnt;
    logic [7:0]    rd;
    logic          exp7;
    logic          reread;
    logic          fail_seen;
    logic          stage;
    logic          resetting;

    assign cyc = seq_cycle(resetting ? OP_POLL : cmd.op, idx, cmd.addr, cmd.data);

    // the window restarts on every accepted sector strobe; extra sectors after it
    // closes would start nothing, so they are refused without a write
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            win_cnt <= 11'h000;
        end else if (state == S_WRITE && ph == WP_CYC + 4'h1 && cyc.last &&
                     (cmd.op == OP_SECT || cmd.op == OP_ADD_SECT) && !resetting) begin
            win_cnt <= SEWIN_CYC;
        end else if (win_cnt != 11'h000) begin
            win_cnt <= win_cnt - 11'h001;
        end
    end

    // ------------------------------------------------------------------
    // sequencer and pins
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state     <= S_IDLE;
            cmd       <= '0;
            idx       <= 3'h0;
            ph        <= 4'h0;
            wait_cnt  <= 11'h000;
            rd        <= 8'h00;
            exp7      <= 1'b1;
            reread    <= 1'b0;
            fail_seen <= 1'b0;
            stage     <= 1'b0;
            resetting <= 1'b0;
            CMD_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP       <= '0;
            CE_N      <= 1'b1;
            OE_N      <= 1'b1;
            WE_N      <= 1'b1;
            ADDR      <= '0;
            DQ_OUT    <= 8'h00;
            DQ_OE     <= 1'b0;
        end else begin
            RSP_VALID <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    CMD_READY <= 1'b1;
                    if (CMD_VALID && CMD_READY) begin
                        CMD_READY <= 1'b0;
                        cmd       <= CMD;
                        idx       <= 3'h0;
                        ph        <= 4'h0;
                        reread    <= 1'b0;
                        fail_seen <= 1'b0;
                        stage     <= 1'b0;
                        RSP       <= '0;
                        // program completes when the poll bit equals the written bit 7,
                        // erase and suspend when it reads 1
                        exp7      <= (CMD.op == OP_PROG) ? CMD.data[7] : 1'b1;
                        if (CMD.op == OP_ADD_SECT && win_cnt == 11'h000) begin
                            RSP.reject <= 1'b1;
                            RSP_VALID  <= 1'b1;
                            CMD_READY  <= 1'b1;
                        end else if (CMD.op == OP_READ || CMD.op == OP_POLL ||
                                     CMD.op == OP_ADD_SECT) begin
                            state <= S_READ;
                        end else begin
                            state <= S_WRITE;
                        end
                    end
                end
                S_WRITE: begin
                    ph <= ph + 4'h1;
                    if (ph == 4'h0) begin
                        ADDR   <= cyc.addr;
                        DQ_OUT <= cyc.data;
                        DQ_OE  <= 1'b1;
                        CE_N   <= 1'b0;
                    end else if (ph == 4'h1) begin
                        WE_N <= 1'b0;
                    end else if (ph == WP_CYC + 4'h1) begin
                        WE_N <= 1'b1; // device latches data on this rising edge
                    end else if (ph == WP_CYC + 4'h2) begin
                        CE_N  <= 1'b1;
                        DQ_OE <= 1'b0;
                    end else if (ph >= WP_CYC + 4'h3) begin
                        ph  <= 4'h0;
                        idx <= idx + 3'h1;
                        if (cyc.last) begin
                            idx <= 3'h0;
                            if (resetting) begin
                                resetting <= 1'b0;
                                RSP_VALID <= 1'b1;
                                state     <= S_IDLE;
                            end else begin
                                unique case (cmd.op)
                                    // status is valid right after the last strobe
                                    OP_PROG, OP_CHIP: state <= S_READ;
                                    OP_ADD_SECT:      state <= S_READ;
                                    OP_SUSPEND: begin
                                        wait_cnt <= SUSP_CYC;
                                        state    <= S_WAIT;
                                    end
                                    default: begin
                                        // sector erase returns at once so extra sectors
                                        // can follow inside the window
                                        RSP_VALID <= 1'b1;
                                        state     <= S_IDLE;
                                    end
                                endcase
                            end
                        end
                    end
                end
                S_WAIT: begin
                    wait_cnt <= wait_cnt - 11'h001;
                    if (wait_cnt == 11'h001) state <= S_READ;
                end
                S_READ: begin
                    // each read is a fresh output-enable pulse, which is what the
                    // toggle bit counts
                    ph <= ph + 4'h1;
                    if (ph == 4'h0) begin
                        ADDR <= cmd.addr;
                        CE_N <= 1'b0;
                        OE_N <= 1'b0;
                    end else if (ph >= ACC_CYC && dq_s2 == dq_s3) begin
                        rd    <= dq_s3;
                        OE_N  <= 1'b1;
                        CE_N  <= 1'b1;
                        ph    <= 4'h0;
                        state <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    state <= S_READ;
                    if (cmd.op == OP_READ) begin
                        RSP.data  <= rd;
                        RSP_VALID <= 1'b1;
                        state     <= S_IDLE;
                    end else if (cmd.op == OP_ADD_SECT) begin
                        if (rd[ERASE_WINDOW_BIT]) begin
                            // high before or after the write: erase already started
                            RSP.reject <= 1'b1;
                            RSP_VALID  <= 1'b1;
                            state      <= S_IDLE;
                        end else if (!stage) begin
                            stage <= 1'b1;
                            state <= S_WRITE;
                        end else begin
                            RSP_VALID <= 1'b1;
                            state     <= S_IDLE;
                        end
                    end else if (rd[POLL_STATUS_BIT] == exp7) begin
                        // bits 0..6 may lag the poll bit; only a second match is trusted
                        reread <= 1'b1;
                        if (reread) begin
                            RSP.data  <= rd;
                            RSP.fail  <= fail_seen;
                            RSP_VALID <= 1'b1;
                            state     <= S_IDLE;
                        end
                    end else if (fail_seen) begin
                        // limit exceeded and still no match: lock-up, reset the device
                        RSP.fail  <= 1'b1;
                        resetting <= 1'b1;
                        idx       <= 3'h0;
                        ph        <= 4'h0;
                        state     <= S_WRITE;
                    end else begin
                        reread <= 1'b0;
                        // one more read after the fail bit rises, since the algorithm
                        // may have finished in the same instant
                        if (rd[TIMEOUT_FAIL_BIT] && cmd.op != OP_SUSPEND) begin
                            fail_seen <= 1'b1;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

endmodule : fwsf_host

`default_nettype wire

// *** fwsf_monitor.sv ***
// fwsf_monitor: concurrent checks on the flash host controller's user and flash pins.
// assumes the bind at the foot reaches every fwsf_host instance; single clock domain.
`timescale 1ns/1ps
`default_nettype none

module fwsf_monitor (
    input  wire logic                    REF_CLK,
    input  wire logic                    ARST_N,
    input  wire logic                    CMD_VALID,
    input  wire logic                    CMD_READY,
    input  wire logic                    RSP_VALID,
    input  wire fwsf_pkg::fwsf_rsp_t     RSP,
    input  wire logic                    CE_N,
    input  wire logic                    OE_N,
    input  wire logic                    WE_N,
    input  wire logic [fwsf_pkg::AW-1:0] ADDR,
    input  wire logic [7:0]              DQ_OUT,
    input  wire logic                    DQ_OE
);
    import fwsf_pkg::*;
    logic f0_sent;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // a fail answer is only honest once the device has been sent back to read mode
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            f0_sent <= 1'h0;
        end else begin
            f0_sent <= !(CMD_VALID && CMD_READY) && (f0_sent || (!WE_N && DQ_OUT == CMD_RESET));
        end
    end
    property p_we_frame; !WE_N |-> !CE_N && OE_N && DQ_OE; endproperty
    a_we_frame: assert property (p_we_frame) else $error("write strobe outside a write frame");
    property p_we_width; $fell(WE_N) |-> ##1 !WE_N ##1 WE_N; endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
    property p_we_stable; !WE_N |-> $stable(ADDR) && $stable(DQ_OUT); endproperty
    a_we_stable: assert property (p_we_stable) else $error("address or data moved in write");
    property p_no_clash; !OE_N |-> !CE_N && !DQ_OE && WE_N; endproperty
    a_no_clash: assert property (p_no_clash) else $error("read overlaps drive or write");
    property p_oe_width; $fell(OE_N) |-> !OE_N [*5]; endproperty
    a_oe_width: assert property (p_oe_width) else $error("read strobe too short");
    property p_rsp_pulse; RSP_VALID |=> !RSP_VALID; endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer strobe longer than one cycle");
    property p_ready_back; RSP_VALID |=> CMD_READY; endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not back after answer");
    property p_take; CMD_VALID && CMD_READY |=> !CMD_READY || RSP_VALID; endproperty
    a_take: assert property (p_take) else $error("ready stayed high after a take");
    property p_fail_reset; RSP_VALID && RSP.fail |-> f0_sent; endproperty
    a_fail_reset: assert property (p_fail_reset) else $error("fail answered without reset write");
endmodule : fwsf_monitor

bind fwsf_host fwsf_monitor u_mon (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP(RSP), .CE_N(CE_N), .OE_N(OE_N),
    .WE_N(WE_N), .ADDR(ADDR), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE));
`default_nettype wire

// *** fwsf_flash_model.sv ***
// fwsf_flash_model: behavioural byte-wide flash answering command writes and status reads.
// assumes pins wired straight to the host; ref_clk only paces the internal timers.
`timescale 1ns/1ps
`default_nettype none

module fwsf_flash_model #(
    parameter int         PROG_CYC    = 60,
    parameter int         PROT_CYC    = 40,
    parameter int         ERASE_CYC   = 600,
    parameter int         ALLPROT_CYC = 2000,
    parameter int         WIN_CYC     = 1000,
    parameter logic [4:0] PROT_SECT   = 5'h1F
) (
    input  wire logic                    ref_clk,
    input  wire logic                    ce_n,
    input  wire logic                    oe_n,
    input  wire logic                    we_n,
    input  wire logic [fwsf_pkg::AW-1:0] addr,
    input  wire logic [7:0]              wr_data,
    output wire logic [7:0]              rd_data
);
    import fwsf_pkg::*;
    typedef enum logic [2:0] {M_READ, M_PROG, M_WIN, M_ERASE, M_SUSP, M_LOCK} fwsf_mode_t;
    fwsf_mode_t    mode = M_READ;
    logic [7:0]    mem [logic [AW-1:0]];
    logic [7:0]    wdat = 8'h00;
    logic [7:0]    last = 8'h00;
    logic [AW-1:0] padr;
    logic [31:0]   esect = 32'h0;
    logic [2:0]    seq = 3'h0;
    logic          tog6 = 1'h0;
    logic          tog2 = 1'h0;
    logic          in_susp = 1'h0;
    logic          keep = 1'h0;
    int            cnt = 0;
    wire logic     rd_n = ce_n | oe_n;

    function automatic logic [7:0] rd_mem(input logic [AW-1:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction : rd_mem

    function automatic logic [7:0] rd_val(input logic [AW-1:0] a);
        logic [7:0] v;
        v = rd_mem(a);
        case (mode)
            M_PROG, M_LOCK: v = {~wdat[7], tog6, mode == M_LOCK, v[4], 1'h0, 1'h1, v[1:0]};
            M_WIN:   v = {1'h0, tog6, 1'h0, v[4], 1'h0, tog2, v[1:0]};
            M_ERASE: v = {1'h0, tog6, 1'h0, v[4], 1'h1, tog2, v[1:0]};
            M_SUSP:  v = esect[a[20:16]] ? {3'h6, v[4], 1'h0, tog2, v[1:0]} : v;
            default: v = v;
        endcase
        return v;
    endfunction : rd_val

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
        if (mode == M_LOCK) begin
            mode = (d == CMD_RESET) ? M_READ : M_LOCK;
        end else if (mode == M_WIN && d == CMD_SECT) begin
            esect[a[20:16]] = 1'h1;
            cnt = WIN_CYC;
        end else if ((mode == M_WIN || (mode == M_ERASE && esect != 32'hFFFFFFFF)) && d == CMD_SUSP) begin
            cnt = (mode == M_WIN) ? ERASE_CYC : cnt;
            mode = M_SUSP;
            tog6 = ~tog6;
        end else if (mode == M_SUSP && seq == 3'h0 && d == CMD_RESUME) begin
            mode = M_ERASE;
            tog6 = ~tog6;
        end else if (mode == M_WIN) begin
            mode = M_READ;
        end else if (mode == M_READ || mode == M_SUSP) begin
            case (seq)
                3'h0, 3'h4: seq = (a == UNLOCK_A1 && d == UNLOCK_D1) ? seq + 3'h1 : 3'h0;
                3'h1, 3'h5: seq = (a == UNLOCK_A2 && d == UNLOCK_D2) ? seq + 3'h1 : 3'h0;
                3'h2: seq = (a != UNLOCK_A1) ? 3'h0 : (d == CMD_PROG) ? 3'h3 :
                            (d == CMD_ESETUP && mode == M_READ) ? 3'h4 : 3'h0;
                3'h3: begin
                    seq = 3'h0;
                    padr = a;
                    wdat = d;
                    in_susp = (mode == M_SUSP);
                    keep = (a[20:16] == PROT_SECT);
                    mode = (!keep && |(d & ~rd_mem(a))) ? M_LOCK : M_PROG;
                    cnt = keep ? PROT_CYC : PROG_CYC;
                end
                default: begin
                    seq = 3'h0;
                    esect = (d == CMD_CHIP) ? 32'hFFFFFFFF : 32'h1 << a[20:16];
                    mode = (d == CMD_CHIP) ? M_ERASE : (d == CMD_SECT) ? M_WIN : M_READ;
                    cnt = (d == CMD_CHIP) ? ERASE_CYC : WIN_CYC;
                end
            endcase
        end
    endtask : wr

    // commands latch on the closing edge of the write strobe
    always @(posedge we_n) begin
        if (!ce_n && oe_n) begin
            wr(addr, wr_data);
        end
    end

    always @(posedge ref_clk) begin
        if (mode inside {M_PROG, M_WIN, M_ERASE} && cnt > 0) begin
            cnt = cnt - 1;
        end else if (mode == M_PROG) begin
            mem[padr] = keep ? rd_mem(padr) : wdat;
            mode = in_susp ? M_SUSP : M_READ;
        end else if (mode == M_WIN) begin
            mode = M_ERASE;
            cnt = (esect == 32'h1 << PROT_SECT) ? ALLPROT_CYC : ERASE_CYC;
        end else if (mode == M_ERASE) begin
            foreach (mem[k]) begin
                mem[k] = (esect[k[20:16]] && k[20:16] != PROT_SECT) ? 8'hFF : mem[k];
            end
            mode = M_READ;
        end
    end

    // status is frozen when a read opens; a released bus shows the inverse, nothing pulls it
    always @(negedge rd_n) begin
        tog6 = (mode == M_SUSP) ? tog6 : ~tog6;
        tog2 = ~tog2;
        last = rd_val(addr);
    end
    assign rd_data = rd_n ? ~last : last;
endmodule : fwsf_flash_model
`default_nettype wire

// *** tb_top.sv ***
// tb_top: issues user requests to the flash host and checks answers against the flash model.
// assumes REF_CLK at 20 MHz; model timers count in those cycles.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import fwsf_pkg::*;
    logic          ref_clk = 1'h0;
    logic          arst_n;
    logic          cmd_valid;
    fwsf_cmd_t     cmd;
    logic          cmd_ready;
    logic          rsp_valid;
    fwsf_rsp_t     rsp;
    logic          ce_n;
    logic          oe_n;
    logic          we_n;
    logic [AW-1:0] addr;
    logic [7:0]    dq_out;
    logic          dq_oe;
    logic [7:0]    t;
    wire logic [7:0] dev_q;
    wire logic [7:0] bus = dq_oe ? dq_out : dev_q;
    int            errors = 0;
    int            tests_run = 0;

    always #25 ref_clk = ~ref_clk;

    fwsf_host u_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .CMD_VALID(cmd_valid), .CMD(cmd),
        .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP(rsp), .CE_N(ce_n), .OE_N(oe_n),
        .WE_N(we_n), .ADDR(addr), .DQ_IN(bus), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
    fwsf_flash_model u_flash (.ref_clk(ref_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(addr), .wr_data(bus), .rd_data(dev_q));

    task automatic test_done;
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // one request, held until taken, then a bounded wait for its answer
    task automatic op(input fwsf_op_t o, input logic [AW-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cmd_valid <= 1'h1;
        cmd <= '{o, a, d};
        do @(negedge ref_clk); while (cmd_ready !== 1'h1 && ++n < 100);
        if (n >= 100) begin
            errors++;
            $display("ERROR %0t: request not taken, op %0d", $time, o);
            test_done();
        end
        @(posedge ref_clk);
        cmd_valid <= 1'h0;
        n = 0;
        do @(negedge ref_clk); while (rsp_valid !== 1'h1 && ++n < 20000);
        if (n >= 20000) begin
            errors++;
            $display("ERROR %0t: no answer to op %0d", $time, o);
            test_done();
        end
    endtask : op

    task automatic chk(input logic [9:0] exp, input logic [9:0] mask);
        tests_run++;
        if ((rsp & mask) !== (exp & mask)) begin
            errors++;
            $display("ERROR %0t: answer %h expected %h mask %h", $time, rsp, exp, mask);
        end
    endtask : chk

    initial begin
        arst_n = 1'h0;
        cmd_valid = 1'h0;
        cmd = '0;
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'h1;
        op(OP_READ, 21'h020010, 8'h00);
        chk({8'hFF, 2'h0}, 10'h3FF);
        op(OP_PROG, 21'h020010, 8'h5A);
        chk({8'h5A, 2'h0}, 10'h3FF);
        op(OP_READ, 21'h020010, 8'h00);
        chk({8'h5A, 2'h0}, 10'h3FF);
        op(OP_PROG, 21'h020010, 8'hFF);
        chk(10'h002, 10'h002);
        op(OP_READ, 21'h020010, 8'h00);
        chk({8'h5A, 2'h0}, 10'h3FF);
        op(OP_PROG, 21'h1F0004, 8'h80);
        chk({8'hFF, 2'h0}, 10'h3FF);
        op(OP_SECT, 21'h020010, 8'h00);
        chk(10'h000, 10'h003);
        op(OP_ADD_SECT, 21'h030000, 8'h00);
        chk(10'h000, 10'h001);
        op(OP_SUSPEND, 21'h020010, 8'h00);
        chk({8'hC0, 2'h0}, 10'h3A0);
        t = rsp.data;
        op(OP_READ, 21'h020010, 8'h00);
        chk({8'hC0, 2'h0} | {5'h0, ~t[2], 4'h0}, 10'h3B0);
        op(OP_PROG, 21'h000100, 8'h33);
        chk({8'h33, 2'h0}, 10'h3FF);
        op(OP_RESUME, 21'h020010, 8'h00);
        op(OP_POLL, 21'h020010, 8'h00);
        chk({8'hFF, 2'h0}, 10'h3FF);
        op(OP_READ, 21'h000100, 8'h00);
        chk({8'h33, 2'h0}, 10'h3FF);
        op(OP_ADD_SECT, 21'h030000, 8'h00);
        chk(10'h001, 10'h001);
        op(OP_CHIP, 21'h000100, 8'h00);
        chk({8'hFF, 2'h0}, 10'h3FF);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
